// *** verilog/ucl_pkg.sv ***
// ucl_pkg: constants and types shared by the unified cache line control
// assumes 32-bit physical addresses, 16-byte lines and a single core clock
package ucl_pkg;
	localparam int SET_LSB  = 4;
	localparam int SET_MSB  = 10;
	localparam int TAG_LSB  = 11;
	localparam int TAG_W    = 21;
	localparam int SET_W    = 7;
	localparam int NUM_SETS = 128;
	localparam int NUM_WAYS = 4;
	localparam int LINE_W   = 128;
	localparam int ACR_LSB  = 24;
	localparam int CCR_W    = 8;
	// cache control register fields
	localparam int CCR_EN   = 0;
	localparam int CCR_HALF_LOCK_BIT = 1;
	localparam int CCR_FBE  = 2;
	localparam int CCR_SBE  = 3;
	localparam int CCR_DPOL = 4;
	localparam int CCR_DRO  = 6;
	localparam int CCR_INVA = 7;
	localparam logic [1:0] LAST_BEAT = 2'h3;
	localparam logic [1:0] TT_NORMAL = 2'h0;
	localparam logic [1:0] RR_LOCK   = 2'h2;
	localparam logic [3:0] MASK_BYTE = 4'h1;
	localparam logic [3:0] MASK_WORD = 4'h3;
	localparam logic [3:0] MASK_LONG = 4'hF;
	typedef enum logic [1:0] {
		UCL_POL_WT,
		UCL_POL_CB,
		UCL_POL_INH_P,
		UCL_POL_INH_I
	} ucl_pol_t;
	typedef enum logic [1:0] {
		UCL_OP_READ,
		UCL_OP_WRITE,
		UCL_OP_PUSH
	} ucl_op_t;
	typedef enum logic [1:0] {
		UCL_SZ_BYTE,
		UCL_SZ_WORD,
		UCL_SZ_LONG
	} ucl_size_t;
endpackage: ucl_pkg

// *** verilog/ucl_victim_pick.sv ***
// ucl_victim_pick: chooses the way to allocate within one set
// assumes the caller advances the round-robin pointer after each allocation
`timescale 1ns/10ps
module ucl_victim_pick (
	input  wire logic [3:0] line_valid,
	input  wire logic [1:0] rr_ptr,
	input  wire logic       half_lock,
	output logic [1:0]      victim_way,
	output logic            victim_free
);
	always_comb begin
		victim_free = ~&line_valid;
		// locked half keeps ways 0 and 1 out of replacement
		victim_way = half_lock ? {1'b1, rr_ptr[0]} : rr_ptr; // [RQ9] [RQ10]
		for (int i = ucl_pkg::NUM_WAYS - 1; i >= 0; i--) begin
			if (!line_valid[i]) begin
				victim_way = 2'(i); // [RQ8]
			end
		end
	end
endmodule: ucl_victim_pick

// *** verilog/ucl_cache_ctrl.sv ***
// ucl_cache_ctrl: lookup, allocation, replacement and line state of a 4-way unified cache
// assumes a core that holds a request until req_ready and a bus that answers in beats
// Notes on behaviour
// RQ1 - a line with present flag clear never hits, whatever its dirty flag says
// RQ2 - present and dirty means cache is newest; present alone means memory matches
// RQ3 - the push-line operation invalidates a valid matching line
// RQ4 - reset does not touch line state; software invalidates all before enabling
// RQ5 - reset disables the cache and clears the whole control register
// RQ6 - address bits 10..4 pick one of 128 sets
// RQ7 - hit needs tag bits 31..11 equal and present set; no type bits in tags
// RQ8 - allocation takes an invalid way first, lowest number first
// RQ9 - with all ways valid a 2-bit counter picks the victim, advancing per allocation
// RQ10 - half lock confines replacement to ways 2 and 3
// RQ11 - clean victims are dropped; dirty ones go to push buffer, written after fill
// RQ12 - allocation writes the tag, fills the line, then sets present
// RQ13 - read misses allocate when cacheable; write misses only in copyback
// RQ14 - copyback write miss fills, sets present and dirty, merges data, no memory write
// RQ15 - read hit returns data with no state change and no replacement
// RQ16 - write hit merges data; write-through writes out, copyback sets dirty
// RQ17 - misaligned access becomes two cache accesses
// RQ18 - a line becomes valid only once every longword is loaded
// RQ19 - read fill fetches the wanted longword first and answers at once
// RQ20 - inhibited accesses bypass; normal instruction reads may use the fill buffer
// RQ21 - an inhibited access neither pushes nor invalidates a matching line
// RQ22 - policy and write protect come from matching region or the defaults
// RQ23 - write-through writes always go out, flagged bufferable when enabled
// RQ24 - lines are four longwords, four ways per set, loaded by a burst
// RQ25 - while disabled every access is inhibited and line arrays stay untouched
`timescale 1ns/10ps
module ucl_cache_ctrl (
	input  wire logic               clk_sys,
	input  wire logic               nrst,
	input  wire logic               ccr_wr,
	input  wire logic [7:0]         ccr_wdata,
	output logic [7:0]              ccr_rdata,
	input  wire logic               acr0_en,
	input  wire logic [7:0]         acr0_base,
	input  wire logic [7:0]         acr0_mask,
	input  wire ucl_pkg::ucl_pol_t  acr0_pol,
	input  wire logic               acr0_ro,
	input  wire logic               acr1_en,
	input  wire logic [7:0]         acr1_base,
	input  wire logic [7:0]         acr1_mask,
	input  wire ucl_pkg::ucl_pol_t  acr1_pol,
	input  wire logic               acr1_ro,
	input  wire logic               req_valid,
	output logic                    req_ready,
	input  wire ucl_pkg::ucl_op_t   req_op,
	input  wire logic [31:0]        req_addr,
	input  wire ucl_pkg::ucl_size_t req_size,
	input  wire logic [31:0]        req_wdata,
	input  wire logic               req_instr,
	input  wire logic [1:0]         req_tt,
	output logic                    resp_valid,
	output logic                    resp_err,
	output logic [31:0]             resp_rdata,
	output logic                    rd_req,
	output logic [31:0]             rd_addr,
	output logic                    rd_line,
	input  wire logic               rd_ack,
	input  wire logic               rd_beat,
	input  wire logic [31:0]        rd_data,
	output logic                    ext_wr_valid,
	input  wire logic               ext_wr_ready,
	output logic [31:0]             ext_wr_addr,
	output logic [31:0]             ext_wr_data,
	output logic [3:0]              ext_wr_be,
	output logic                    ext_wr_buffered,
	output logic                    push_valid,
	input  wire logic               push_ready,
	output logic [31:0]             push_addr,
	output logic [127:0]            push_data
);
	typedef enum logic [2:0] {
		S_IDLE,
		S_LOOK,
		S_RDREQ,
		S_FILL,
		S_EXTWR,
		S_PUSH,
		S_FIN
	} ucl_state_t;

	typedef struct packed {
		ucl_state_t       st;
		logic [7:0]       ccr;
		logic [31:0]      addr;
		logic [1:0]       off;
		ucl_pkg::ucl_op_t op;
		logic             instr;
		logic [1:0]       tt;
		logic [3:0]       be;
		logic [3:0]       be_hi;
		logic [31:0]      wd;
		logic [31:0]      wd_hi;
		logic             part;
		logic [63:0]      rdat;
		logic             err;
		logic             alloc;
		logic [1:0]       way;
		logic             line;
		logic [1:0]       beat;
		logic [127:0]     lbuf;
		logic             fb_valid;
		logic [27:0]      fb_tag;
		logic             pb_valid;
		logic [27:0]      pb_addr;
		logic [127:0]     pb_data;
		logic [1:0]       rr;
		logic             resp_done;
		logic             resp_valid;
		logic             resp_err;
		logic [31:0]      resp_data;
	} ucl_ctl_t;

	ucl_ctl_t st_reg;
	ucl_ctl_t st_next;

	// line state arrays: no reset on purpose, contents survive reset [RQ4]
	logic [3:0]   valid_mem [ucl_pkg::NUM_SETS];
	logic [3:0]   dirty_mem [ucl_pkg::NUM_SETS];
	logic [20:0]  tag_mem   [ucl_pkg::NUM_SETS * ucl_pkg::NUM_WAYS];
	logic [127:0] data_mem  [ucl_pkg::NUM_SETS * ucl_pkg::NUM_WAYS];

	logic [6:0]        cur_set;
	logic [20:0]       cur_tag;
	logic [3:0]        vrow;
	logic [3:0]        drow;
	logic [3:0]        tag_eq;
	logic [3:0]        hitv;
	logic              hit;
	logic [1:0]        hway;
	logic [127:0]      hline;
	logic [31:0]       hword;
	logic [1:0]        vway;
	logic              vfree;
	logic              a0_hit;
	logic              a1_hit;
	ucl_pkg::ucl_pol_t pol;
	logic              ro;
	logic              cacheable;
	logic              fb_hit;
	logic              do_alloc;
	logic              rd_take;
	logic [31:0]       rd_w;
	logic              resp_early;
	logic [1:0]        fword;
	logic [127:0]      fill_line;
	logic              tv_we;
	logic [1:0]        tv_way;
	logic              tv_v;
	logic              tv_d;
	logic              dw_we;
	logic [127:0]      dw_line;
	logic              inv_all;
	logic [3:0]        size_mask;
	logic [7:0]        be8;
	logic [63:0]       wd8;

	function automatic logic [127:0] merge(input logic [127:0] ln, input logic [1:0] wi,
		input logic [3:0] be, input logic [31:0] wd);
		logic [127:0] r;
		r = ln;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[{wi, 2'(b), 3'h0} +: 8] = wd[8*b +: 8];
			end
		end
		return r;
	endfunction: merge

	function automatic logic [31:0] fmt(input logic [63:0] r, input logic [1:0] o);
		logic [63:0] s;
		s = r >> {o, 3'h0};
		return s[31:0];
	endfunction: fmt

	ucl_victim_pick u_pick (
		.line_valid  (vrow),
		.rr_ptr      (st_reg.rr),
		.half_lock   (st_reg.ccr[ucl_pkg::CCR_HALF_LOCK_BIT]),
		.victim_way  (vway),
		.victim_free (vfree)
	);

	// lookup and attribute decode from the registered access address; byte lanes from the live request
	always_comb begin
		cur_set = st_reg.addr[ucl_pkg::SET_MSB:ucl_pkg::SET_LSB]; // [RQ6]
		cur_tag = st_reg.addr[31:ucl_pkg::TAG_LSB];
		vrow = valid_mem[cur_set];
		drow = dirty_mem[cur_set];
		for (int w = 0; w < ucl_pkg::NUM_WAYS; w++) begin
			tag_eq[w] = tag_mem[{cur_set, 2'(w)}] == cur_tag;
		end
		hitv = tag_eq & vrow; // [RQ1] [RQ7]
		hit = (|hitv) && st_reg.ccr[ucl_pkg::CCR_EN]; // [RQ25]
		hway = 2'h0;
		for (int w = ucl_pkg::NUM_WAYS - 1; w >= 0; w--) begin
			if (hitv[w]) begin
				hway = 2'(w);
			end
		end
		hline = data_mem[{cur_set, hway}];
		hword = hline[{st_reg.addr[3:2], 5'h00} +: 32];
		a0_hit = acr0_en && ((st_reg.addr[31:ucl_pkg::ACR_LSB] ^ acr0_base) & ~acr0_mask) == 8'h00;
		a1_hit = acr1_en && ((st_reg.addr[31:ucl_pkg::ACR_LSB] ^ acr1_base) & ~acr1_mask) == 8'h00;
		// region 0 wins over region 1, defaults last [RQ22]
		pol = a0_hit ? acr0_pol : a1_hit ? acr1_pol
			: ucl_pkg::ucl_pol_t'(st_reg.ccr[ucl_pkg::CCR_DPOL +: 2]);
		ro = a0_hit ? acr0_ro : a1_hit ? acr1_ro : st_reg.ccr[ucl_pkg::CCR_DRO];
		cacheable = st_reg.ccr[ucl_pkg::CCR_EN]
			&& (pol == ucl_pkg::UCL_POL_WT || pol == ucl_pkg::UCL_POL_CB); // [RQ25]
		fb_hit = st_reg.fb_valid && st_reg.fb_tag == st_reg.addr[31:4];
		fword = st_reg.addr[3:2] + st_reg.beat;
		fill_line = st_reg.lbuf;
		fill_line[{fword, 5'h00} +: 32] = rd_data;
		unique case (req_size)
			ucl_pkg::UCL_SZ_BYTE: size_mask = ucl_pkg::MASK_BYTE;
			ucl_pkg::UCL_SZ_WORD: size_mask = ucl_pkg::MASK_WORD;
			default:              size_mask = ucl_pkg::MASK_LONG;
		endcase
		be8 = {4'h0, size_mask} << req_addr[1:0];
		wd8 = {32'h0, req_wdata} << {req_addr[1:0], 3'h0};
	end

	always_comb begin
		st_next = st_reg;
		st_next.resp_valid = 1'b0;
		tv_we = 1'b0;
		tv_way = hway;
		tv_v = 1'b0;
		tv_d = 1'b0;
		dw_we = 1'b0;
		dw_line = hline;
		inv_all = 1'b0;
		do_alloc = 1'b0;
		rd_take = 1'b0;
		rd_w = hword;
		resp_early = 1'b0;
		if (ccr_wr) begin
			st_next.ccr = ccr_wdata;
			st_next.ccr[ucl_pkg::CCR_INVA] = 1'b0;
			inv_all = ccr_wdata[ucl_pkg::CCR_INVA];
		end
		if (inv_all) begin
			st_next.fb_valid = 1'b0; // [RQ20]
		end
		unique case (st_reg.st)
			S_IDLE: begin
				if (req_valid) begin
					st_next.addr = {req_addr[31:2], 2'h0};
					st_next.off = req_addr[1:0];
					st_next.op = req_op;
					st_next.instr = req_instr;
					st_next.tt = req_tt;
					st_next.be = be8[3:0];
					st_next.be_hi = (req_op == ucl_pkg::UCL_OP_PUSH) ? 4'h0 : be8[7:4];
					st_next.wd = wd8[31:0];
					st_next.wd_hi = wd8[63:32];
					st_next.part = 1'b0;
					st_next.rdat = '0;
					st_next.err = 1'b0;
					st_next.resp_done = 1'b0;
					st_next.st = S_LOOK;
				end
			end
			S_LOOK: begin
				st_next.st = S_FIN;
				unique case (st_reg.op)
					ucl_pkg::UCL_OP_PUSH: begin
						if (hit) begin
							tv_we = 1'b1; // [RQ3]
							if (drow[hway]) begin
								st_next.pb_valid = 1'b1;
								st_next.pb_addr = {cur_tag, cur_set};
								st_next.pb_data = hline;
								st_next.st = S_PUSH;
							end
						end
					end
					ucl_pkg::UCL_OP_WRITE: begin
						if (ro) begin
							st_next.err = 1'b1;
						end else if (cacheable && hit) begin
							dw_we = 1'b1; // [RQ16]
							dw_line = merge(hline, st_reg.addr[3:2], st_reg.be, st_reg.wd);
							if (pol == ucl_pkg::UCL_POL_CB) begin
								tv_we = 1'b1;
								tv_v = 1'b1;
								tv_d = 1'b1; // [RQ2]
							end else begin
								st_next.st = S_EXTWR; // [RQ23]
							end
						end else if (cacheable && pol == ucl_pkg::UCL_POL_CB) begin
							do_alloc = 1'b1; // [RQ13] [RQ14]
						end else begin
							// matching lines are left alone when inhibited [RQ21]
							st_next.st = S_EXTWR; // [RQ20]
						end
					end
					ucl_pkg::UCL_OP_READ: begin
						if (cacheable && hit) begin
							rd_take = 1'b1; // [RQ15]
						end else if (cacheable) begin
							do_alloc = 1'b1; // [RQ13]
						end else if (st_reg.ccr[ucl_pkg::CCR_FBE] && st_reg.instr
							&& st_reg.tt == ucl_pkg::TT_NORMAL) begin
							if (fb_hit) begin
								rd_take = 1'b1; // [RQ20]
								rd_w = st_reg.lbuf[{st_reg.addr[3:2], 5'h00} +: 32];
							end else begin
								st_next.line = 1'b1;
								st_next.alloc = 1'b0;
								st_next.st = S_RDREQ;
							end
						end else begin
							st_next.line = 1'b0; // [RQ21]
							st_next.alloc = 1'b0;
							st_next.st = S_RDREQ;
						end
					end
					default: begin
						st_next.err = 1'b1;
					end
				endcase
			end
			S_RDREQ: begin
				if (rd_ack) begin
					st_next.beat = 2'h0;
					st_next.st = S_FILL;
					if (st_reg.line) begin
						st_next.fb_valid = 1'b0; // [RQ20]
					end
				end
			end
			S_FILL: begin
				if (rd_beat) begin
					st_next.beat = st_reg.beat + 2'h1;
					st_next.lbuf = fill_line;
					if (st_reg.beat == 2'h0) begin
						rd_take = 1'b1; // [RQ19]
						rd_w = rd_data;
						resp_early = st_reg.line && st_reg.op == ucl_pkg::UCL_OP_READ
							&& st_reg.be_hi == 4'h0;
					end
					if (!st_reg.line) begin
						st_next.st = S_FIN;
					end else if (st_reg.beat == ucl_pkg::LAST_BEAT) begin
						if (st_reg.alloc) begin
							// present only now that all four longwords are in [RQ18] [RQ24]
							tv_we = 1'b1; // [RQ12]
							tv_way = st_reg.way;
							tv_v = 1'b1;
							tv_d = st_reg.op == ucl_pkg::UCL_OP_WRITE; // [RQ14]
							dw_we = 1'b1;
							dw_line = tv_d ? merge(fill_line, st_reg.addr[3:2], st_reg.be,
								st_reg.wd) : fill_line;
						end else begin
							st_next.fb_valid = 1'b1; // [RQ20]
							st_next.fb_tag = st_reg.addr[31:4];
						end
						// dirty victim leaves only after the new line is in [RQ11]
						st_next.st = st_reg.pb_valid ? S_PUSH : S_FIN;
					end
				end
			end
			S_EXTWR: begin
				if (ext_wr_ready) begin
					st_next.st = S_FIN;
				end
			end
			S_PUSH: begin
				if (push_ready) begin
					st_next.pb_valid = 1'b0;
					st_next.st = S_FIN;
				end
			end
			S_FIN: begin
				if (st_reg.be_hi != 4'h0 && !st_reg.err) begin
					st_next.part = 1'b1; // [RQ17]
					st_next.addr = st_reg.addr + 32'h4;
					st_next.be = st_reg.be_hi;
					st_next.wd = st_reg.wd_hi;
					st_next.be_hi = 4'h0;
					st_next.st = S_LOOK;
				end else begin
					st_next.resp_valid = !st_reg.resp_done;
					st_next.resp_err = st_reg.err;
					st_next.resp_data = fmt(st_reg.rdat, st_reg.off);
					st_next.st = S_IDLE;
				end
			end
		endcase
		if (do_alloc) begin
			// victim is invalidated and retagged at once; present waits for the fill
			tv_we = 1'b1; // [RQ11] [RQ12]
			tv_way = vway;
			st_next.way = vway;
			st_next.alloc = 1'b1;
			st_next.line = 1'b1;
			st_next.st = S_RDREQ;
			st_next.rr = st_reg.rr + 2'h1; // [RQ9]
			if (st_reg.ccr[ucl_pkg::CCR_HALF_LOCK_BIT] && !st_next.rr[1]) begin
				st_next.rr = ucl_pkg::RR_LOCK; // [RQ10]
			end
			if (vrow[vway] && dirty_mem[cur_set][vway]) begin
				st_next.pb_valid = 1'b1; // [RQ11]
				st_next.pb_addr = {tag_mem[{cur_set, vway}], cur_set};
				st_next.pb_data = data_mem[{cur_set, vway}];
			end
		end
		if (rd_take) begin
			if (st_reg.part) begin
				st_next.rdat[63:32] = rd_w;
			end else begin
				st_next.rdat[31:0] = rd_w;
			end
		end
		if (resp_early) begin
			st_next.resp_valid = 1'b1;
			st_next.resp_done = 1'b1;
			st_next.resp_err = 1'b0;
			st_next.resp_data = fmt(st_next.rdat, st_reg.off);
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			st_reg <= '0; // [RQ5]
		end else begin
			st_reg <= st_next;
		end
	end

	// line state write port; invalidate-all clears every present flag at once
	always_ff @(posedge clk_sys) begin
		if (inv_all) begin
			for (int s = 0; s < ucl_pkg::NUM_SETS; s++) begin
				valid_mem[s] <= 4'h0;
			end
		end else if (tv_we) begin
			valid_mem[cur_set][tv_way] <= tv_v;
			dirty_mem[cur_set][tv_way] <= tv_d;
			tag_mem[{cur_set, tv_way}] <= cur_tag;
		end
		if (dw_we) begin
			data_mem[{cur_set, tv_way}] <= dw_line;
		end
	end

	assign ccr_rdata = st_reg.ccr;
	assign req_ready = st_reg.st == S_IDLE;
	assign resp_valid = st_reg.resp_valid;
	assign resp_err = st_reg.resp_err;
	assign resp_rdata = st_reg.resp_data;
	assign rd_req = st_reg.st == S_RDREQ;
	assign rd_addr = st_reg.addr;
	assign rd_line = st_reg.line;
	assign ext_wr_valid = st_reg.st == S_EXTWR;
	assign ext_wr_addr = st_reg.addr;
	assign ext_wr_data = st_reg.wd;
	assign ext_wr_be = st_reg.be;
	assign ext_wr_buffered = st_reg.ccr[ucl_pkg::CCR_SBE] && pol == ucl_pkg::UCL_POL_WT; // [RQ23]
	assign push_valid = st_reg.st == S_PUSH;
	assign push_addr = {st_reg.pb_addr, 4'h0};
	assign push_data = st_reg.pb_data;

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	rd_hit_quiet_a: assert property ((st_reg.st == S_LOOK && st_reg.op == ucl_pkg::UCL_OP_READ
		&& cacheable && hit) |-> !tv_we && !dw_we ##1 st_reg.st == S_FIN) // [RQ15]
		else $error("read hit changed line state");
	no_valid_hit_a: assert property ((st_reg.st == S_LOOK && vrow == 4'h0) |-> !hit) // [RQ1]
		else $error("hit on a set with no present line");
	hit_tag_a: assert property (hit |-> vrow[hway] && tag_eq[hway]) // [RQ7]
		else $error("hit way lacks tag match or present flag");
	lock_way_a: assert property ((do_alloc && st_reg.ccr[ucl_pkg::CCR_HALF_LOCK_BIT] && &vrow)
		|-> vway[1] ##1 st_reg.rr[1]) // [RQ10]
		else $error("locked half chosen for replacement");
	rr_victim_a: assert property ((do_alloc && !st_reg.ccr[ucl_pkg::CCR_HALF_LOCK_BIT] && &vrow)
		|-> vway == st_reg.rr) // [RQ9]
		else $error("victim not taken from the counter");
	fill_valid_a: assert property ((tv_we && tv_v && st_reg.st == S_FILL)
		|-> st_reg.beat == ucl_pkg::LAST_BEAT && rd_beat) // [RQ18]
		else $error("line made present before last beat");
	crit_word_a: assert property ((st_reg.st == S_FILL && rd_beat && st_reg.beat == 2'h0
		&& st_reg.line && st_reg.op == ucl_pkg::UCL_OP_READ && st_reg.be_hi == 4'h0)
		|=> resp_valid && resp_rdata == fmt(st_reg.rdat, st_reg.off)
		&& st_reg.rdat[{st_reg.part, 5'h00} +: 32] == $past(rd_data)) // [RQ19]
		else $error("first beat not passed to the core");
	cb_hit_a: assert property ((st_reg.st == S_LOOK && st_reg.op == ucl_pkg::UCL_OP_WRITE
		&& !ro && hit && cacheable && pol == ucl_pkg::UCL_POL_CB)
		|-> tv_we && tv_d && dw_we ##1 !ext_wr_valid) // [RQ16]
		else $error("copyback write hit handled wrongly");
	wt_miss_a: assert property ((st_reg.st == S_LOOK && st_reg.op == ucl_pkg::UCL_OP_WRITE
		&& !ro && !hit && cacheable && pol == ucl_pkg::UCL_POL_WT)
		|-> !tv_we ##1 ext_wr_valid) // [RQ13]
		else $error("write-through write miss allocated");
	off_quiet_a: assert property ((st_reg.st == S_LOOK && !st_reg.ccr[ucl_pkg::CCR_EN])
		|-> !tv_we && !dw_we) // [RQ25]
		else $error("disabled cache touched line arrays");
	inh_keep_a: assert property ((st_reg.st == S_LOOK && !cacheable
		&& st_reg.op != ucl_pkg::UCL_OP_PUSH) |-> !tv_we && !dw_we) // [RQ21]
		else $error("inhibited access changed a line");
	ccr_reset_a: assert property (!$past(nrst) |-> st_reg.ccr == 8'h00) // [RQ5]
		else $error("control register not cleared by reset");
	split_a: assert property ((st_reg.st == S_FIN && st_reg.be_hi != 4'h0 && !st_reg.err)
		|=> st_reg.st == S_LOOK && st_reg.part && !resp_valid) // [RQ17]
		else $error("misaligned access not split");
endmodule: ucl_cache_ctrl

// *** verif/ucl_bus_model.sv ***
// ucl_bus_model: bus side memory answering fills, external writes and pushes
// assumes each request is held until acknowledged; wait states are random
`timescale 1ns/10ps
module ucl_bus_model (
	input  wire logic         clk_sys,
	input  wire logic         rd_req,
	input  wire logic [31:0]  rd_addr,
	input  wire logic         rd_line,
	output logic              rd_ack,
	output logic              rd_beat,
	output logic [31:0]       rd_data,
	input  wire logic         ext_wr_valid,
	output logic              ext_wr_ready,
	input  wire logic [31:0]  ext_wr_addr,
	input  wire logic [31:0]  ext_wr_data,
	input  wire logic [3:0]   ext_wr_be,
	input  wire logic         push_valid,
	output logic              push_ready,
	input  wire logic [31:0]  push_addr,
	input  wire logic [127:0] push_data
);
	logic [31:0] mem [logic [31:0]];
	logic [31:0] ra, wa, wd;
	logic [1:0]  w;
	function automatic logic [31:0] rdw(input logic [31:0] x);
		return mem.exists(x) ? mem[x] : x ^ 32'h5A5A_5A5A;
	endfunction: rdw
	initial begin
		{rd_ack, rd_beat, ext_wr_ready, push_ready} = 4'h0;
		rd_data = 32'h0;
	end
	// wrapping burst from the wanted word; data line toggles between beats
	always begin
		@(posedge clk_sys);
		#1;
		if (rd_req) begin
			ra = rd_addr;
			repeat ($urandom_range(2)) @(posedge clk_sys);
			#1 rd_ack = 1;
			@(posedge clk_sys);
			#1 rd_ack = 0;
			for (int i = 0; i < (rd_line ? 4 : 1); i++) begin
				repeat ($urandom_range(1)) @(posedge clk_sys);
				w = ra[3:2] + 2'(i);
				#1 rd_beat = 1;
				rd_data = rdw({ra[31:4], w, 2'h0});
				@(posedge clk_sys);
				#1 rd_beat = 0;
				rd_data = ~rd_data;
			end
		end
	end
	always begin
		@(posedge clk_sys);
		#1;
		if (ext_wr_valid) begin
			repeat ($urandom_range(2)) @(posedge clk_sys);
			wa = {ext_wr_addr[31:2], 2'h0};
			wd = rdw(wa);
			for (int i = 0; i < 4; i++)
				if (ext_wr_be[i]) wd[8*i+:8] = ext_wr_data[8*i+:8];
			mem[wa] = wd;
			#1 ext_wr_ready = 1;
			@(posedge clk_sys);
			#1 ext_wr_ready = 0;
		end
	end
	always begin
		@(posedge clk_sys);
		#1;
		if (push_valid) begin
			repeat ($urandom_range(2)) @(posedge clk_sys);
			for (int i = 0; i < 4; i++)
				mem[{push_addr[31:4], 2'(i), 2'h0}] = push_data[32*i+:32];
			#1 push_ready = 1;
			@(posedge clk_sys);
			#1 push_ready = 0;
		end
	end
endmodule: ucl_bus_model

// *** verif/ucl_cache_ctrl_test.sv ***
// ucl_cache_ctrl_test: directed and random core accesses, checked against a memory shadow
// assumes the bus model keeps every written and pushed longword
`timescale 1ns/10ps
module ucl_cache_ctrl_test;
	logic clk_sys = 0, nrst = 0, ccr_wr = 0, req_valid = 0, req_instr = 0;
	logic acr0_en = 1, acr0_ro = 0, acr1_en = 1, acr1_ro = 0;
	logic [7:0] ccr_wdata = 0, acr0_base = 8'h10, acr1_base = 8'h20, acr0_mask = 0;
	logic [7:0] acr1_mask = 0, ccr_rdata;
	ucl_pkg::ucl_pol_t acr0_pol = ucl_pkg::UCL_POL_WT, acr1_pol = ucl_pkg::UCL_POL_INH_P;
	ucl_pkg::ucl_op_t req_op = ucl_pkg::UCL_OP_READ;
	ucl_pkg::ucl_size_t req_size = ucl_pkg::UCL_SZ_LONG;
	logic [31:0] req_addr = 0, req_wdata = 0, resp_rdata, rd_addr, rd_data, push_addr;
	logic [31:0] ext_wr_addr, ext_wr_data, rdat, a, d;
	logic [1:0] req_tt = 0;
	logic [3:0] ext_wr_be;
	logic [127:0] push_data;
	logic req_ready, resp_valid, resp_err, rd_req, rd_line, rd_ack, rd_beat, ext_wr_valid;
	logic ext_wr_ready, ext_wr_buffered, push_valid, push_ready, rerr, wbuf;
	logic [63:0] q;
	logic [31:0] sh [logic [31:0]];
	int n_errors = 0, n_compared = 0, n_rd = 0, n_wr = 0, r = 0, w = 0;
	ucl_cache_ctrl dut_u (.*);
	ucl_bus_model bus_u (.*);
	always #2 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		if (rd_req && rd_ack) n_rd <= n_rd + 1;
		if (ext_wr_valid && ext_wr_ready) n_wr <= n_wr + 1;
		if (ext_wr_valid && ext_wr_ready) wbuf <= ext_wr_buffered;
	end
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("FAIL %s expected %h seen %h", s, e, g);
		end
	endtask: chk
	function automatic logic [31:0] ev(input logic [31:0] x);
		return sh.exists(x) ? sh[x] : x ^ 32'h5A5A_5A5A;
	endfunction: ev
	function automatic logic [31:0] ad(input logic [7:0] g, input int t, s, k);
		return {g, 10'h0, 3'(t), 7'(s), 2'(k), 2'h0};
	endfunction: ad
	task automatic cw(input logic [7:0] v);
		// an early-answered fill may still be running; let it finish first
		while (!req_ready) begin
			@(posedge clk_sys);
			#1;
		end
		ccr_wdata = v;
		ccr_wr = 1;
		@(posedge clk_sys);
		#1 ccr_wr = 0;
	endtask: cw
	task automatic acc(input ucl_pkg::ucl_op_t op, input logic [31:0] x,
		input logic [31:0] wd = 0, input logic ins = 0, input logic [1:0] tt = 0);
		int n = 0;
		req_op = op;
		req_addr = x;
		req_wdata = wd;
		req_instr = ins;
		req_tt = tt;
		req_valid = 1;
		while (!req_ready) begin
			@(posedge clk_sys);
			#1;
		end
		@(posedge clk_sys);
		#1 req_valid = 0;
		while (resp_valid !== 1'b1 && n < 300) begin
			@(posedge clk_sys);
			#1 n++;
		end
		if (n >= 300) chk("resp_valid", 1, 0);
		rdat = resp_rdata;
		rerr = resp_err;
		if (op == ucl_pkg::UCL_OP_WRITE && rerr !== 1'b1) sh[x] = wd;
	endtask: acc
	task automatic rd(input logic [31:0] x, input string s);
		acc(ucl_pkg::UCL_OP_READ, x);
		chk(s, ev(x), rdat);
	endtask: rd
	task automatic cnt(input int dr, input int dw);
		chk("line reads", r + dr, n_rd);
		chk("ext writes", w + dw, n_wr);
		r = n_rd;
		w = n_wr;
	endtask: cnt
	task automatic end_sim();
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask: end_sim
	initial begin
		#200000;
		n_errors++;
		end_sim();
	end
	initial begin
		void'($urandom(65520));
		repeat (4) @(posedge clk_sys);
		#1 nrst = 1;
		chk("ccr", 0, ccr_rdata);
		cw(8'h99);
		chk("ccr", 8'h19, ccr_rdata);
		a = ad(8'h30, 1, 5, 2);
		rd(a, "cb miss");
		cnt(1, 0);
		rd(a, "cb hit");
		cnt(0, 0);
		acc(ucl_pkg::UCL_OP_WRITE, a, 32'hC0DE_0001);
		rd(a, "cb merge");
		cnt(0, 0);
		acc(ucl_pkg::UCL_OP_WRITE, ad(8'h30, 2, 5, 0), 32'h1234_5678);
		cnt(1, 0);
		acc(ucl_pkg::UCL_OP_WRITE, ad(8'h10, 1, 6, 0), 32'h0BAD_F00D);
		cnt(0, 1);
		chk("buffered", 1, wbuf);
		acr0_ro = 1;
		acc(ucl_pkg::UCL_OP_WRITE, ad(8'h10, 1, 6, 1), 32'h1);
		chk("ro error", 1, rerr);
		acr0_ro = 0;
		for (int i = 0; i < 4; i++) rd(ad(8'h30, i, 9, 0), "fill");
		cw(8'h1B);
		for (int i = 4; i < 7; i++) rd(ad(8'h30, i, 9, 0), "locked fill");
		cnt(7, 0);
		rd(ad(8'h30, 0, 9, 1), "way0");
		rd(ad(8'h30, 1, 9, 3), "way1");
		cnt(0, 0);
		cw(8'h19);
		acc(ucl_pkg::UCL_OP_PUSH, a);
		acc(ucl_pkg::UCL_OP_PUSH, ad(8'h30, 2, 5, 0));
		rd(a, "after push");
		cnt(1, 0);
		cw(8'h99);
		rd(a, "after inva");
		cnt(1, 0);
		cw(8'h1D);
		d = ad(8'h20, 0, 3, 1);
		acc(ucl_pkg::UCL_OP_READ, d, 0, 1, 0);
		acc(ucl_pkg::UCL_OP_READ, d + 4, 0, 1, 0);
		chk("fill buffer", ev(d + 4), rdat);
		cnt(1, 0);
		acc(ucl_pkg::UCL_OP_READ, d, 0, 1, 1);
		cnt(1, 0);
		acc(ucl_pkg::UCL_OP_READ, a + 2);
		q = {ev(a + 4), ev(a)} >> 16;
		chk("split read", q[31:0], rdat);
		cw(8'h18);
		rd(a, "disabled");
		cnt(1, 0);
		cw(8'h99);
		repeat (300) begin
			a = ad(8'h10 * 8'($urandom_range(1, 3)), $urandom_range(5), $urandom_range(1),
				$urandom_range(3));
			case ($urandom_range(4))
				0, 1: rd(a, "random read");
				2, 3: acc(ucl_pkg::UCL_OP_WRITE, a, $urandom());
				default: acc(ucl_pkg::UCL_OP_PUSH, a);
			endcase
		end
		end_sim();
	end
endmodule: ucl_cache_ctrl_test
